// ===== hdl/fdc_status_regs.vh
/*
  Register offsets, command codes, status field positions and timer scaling
  for the floppy controller status and timer block.
  Assumes an APB slave with 32-bit aligned words and a 125 MHz clock.
*/
`ifndef FDC_STATUS_REGS_VH
`define FDC_STATUS_REGS_VH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define OFS_COMMAND      12'h000
`define OFS_SPECIFY      12'h004
`define OFS_CONTROL      12'h008
`define OFS_MAIN_STATUS  12'h00c
`define OFS_RESULT_ST0   12'h010
`define OFS_RESULT_ST1   12'h014
`define OFS_EVENTS       12'h018
`define OFS_CYLINDER     12'h01c
`define OFS_TIMERS       12'h020

// ****************************************************************
// Command codes
// ****************************************************************
`define CMD_SPECIFY      5'h03
`define CMD_SENSE_INT    5'h08
`define CMD_SEEK         5'h0f
`define CMD_RECAL        5'h07
`define CMD_READ         5'h06
`define CMD_WRITE        5'h05
`define CMD_SENSE_DRIVE  5'h04

// ****************************************************************
// Status fields
// ****************************************************************
`define TC_NORMAL        2'h0
`define TC_ABNORMAL      2'h1
`define TC_INVALID       2'h2
`define TC_READY_CHG     2'h3
`define SEEK_READY_CODE  3'h3
`define SEEK_NORMAL_CODE 3'h4
`define SEEK_ABNORM_CODE 3'h5
`define ST0_INVALID      8'h80
`define RECAL_MAX_STEPS  7'h4d

// Event input bit positions
`define EV_DRIVE_FAULT   0
`define EV_END_CYL       1
`define EV_CRC           2
`define EV_OVERRUN       3
`define EV_NO_DATA       4
`define EV_WPROT         5
`define EV_MISS_MARK     6
`define EV_SEEK_FAIL     7

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ          125
`define NOMINAL_MHZ      8
`define UNIT_US          1000
// Cycles per ms at nominal clock, stretched by the nominal/actual ratio
`define MS_CYCLES(mhz)   ((`UNIT_US * `CLK_MHZ * `NOMINAL_MHZ) / (mhz))

`endif

// ===== hdl/fdc_status_timer.v
/*
  Command result, seek interrupt and drive timer logic of a floppy
  controller, reached over APB. Assumes the drive side delivers
  synchronised event strobes; drive pins pass two flip-flops here.
*/
`timescale 1ns/100ps
`include "fdc_status_regs.vh"
module fdc_status_timer #(
  parameter MS_CYCLES_8M = `MS_CYCLES(8)
) (
  input  wire        CLOCK_I,
  input  wire        RST_N_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  input  wire        CLOCK_IS_4M_I,
  input  wire        DRIVE_READY_I,
  input  wire        TRACK_ZERO_I,
  input  wire        TWO_SIDED_I,
  input  wire [7:0]  DRIVE_EVENT_I,
  input  wire        RW_DONE_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  output reg         INTERRUPT_O,
  output reg         STEP_O,
  output reg         DIRECTION_O,
  output reg         HEAD_LOAD_O,
  output reg         RW_START_O,
  output reg         PROGRAMMED_TRANSFER_O
);

// ****************************************************************
// Synchronisers
// ****************************************************************
reg  [2:0] pin_meta_reg;
reg  [2:0] pin_sync_reg;
reg        ready_last_reg;
wire       ready_s  = pin_sync_reg[0];
wire       track0_s = pin_sync_reg[1];
wire       twoside_s = pin_sync_reg[2];

always @(posedge CLOCK_I) begin
  pin_meta_reg <= {TWO_SIDED_I, TRACK_ZERO_I, DRIVE_READY_I};
  pin_sync_reg <= pin_meta_reg;
end

// ****************************************************************
// State
// ****************************************************************
localparam ST_IDLE  = 2'h0;
localparam ST_SEEK  = 2'h1;
localparam ST_LOAD  = 2'h2;
localparam ST_XFER  = 2'h3;

reg  [1:0]  state_reg;
reg  [3:0]  head_unload_timer;
reg  [3:0]  step_interval_setting;
reg  [6:0]  head_settle_delay;
reg         programmed_transfer_select;
reg  [7:0]  present_cylinder_number;
reg  [7:0]  target_cyl_reg;
reg         recal_reg;
reg  [6:0]  step_count_reg;
reg  [1:0]  termination_code;
reg  [2:0]  seek_code_reg;
reg         seek_done_flag;
reg         equipment_fault_flag;
reg         drive_not_ready_flag;
reg         end_cyl_flag;
reg         crc_error_flag;
reg         overrun_flag;
reg         no_data_flag;
reg         write_protect_hit_flag;
reg         missing_mark_flag;
reg         sense_pending_reg;
reg         transfer_direction_bit;
reg         request_for_master_bit;
reg  [23:0] tick_reg;
reg  [7:0]  ms_left_reg;
reg  [7:0]  unload_left_reg;
reg  [23:0] unload_tick_reg;

wire [7:0]  first_result_status = {termination_code, seek_done_flag, equipment_fault_flag,
                                   drive_not_ready_flag, 3'h0};
wire [7:0]  result_status_1 = {end_cyl_flag, 1'b0, crc_error_flag, overrun_flag, 1'b0,
                               no_data_flag, write_protect_hit_flag, missing_mark_flag};
// Clock at 4 MHz doubles every interval
wire [31:0] ms_cycles_full = CLOCK_IS_4M_I ? (MS_CYCLES_8M * 2) : MS_CYCLES_8M;
wire [23:0] ms_cycles      = ms_cycles_full[23:0];

function [7:0] step_ms;
  input [3:0] code;
  step_ms = {3'h0, 5'h10 - {1'b0, code}};
endfunction

// ****************************************************************
// APB decode
// ****************************************************************
wire        wr_acc = PSEL_I & PENABLE_I & PWRITE_I & ~PREADY_O;
wire        rd_acc = PSEL_I & PENABLE_I & ~PWRITE_I & ~PREADY_O;
wire [4:0]  cmd = PWDATA_I[4:0];
wire        cmd_wr = wr_acc && (PADDR_I == `OFS_COMMAND);
wire        is_known = (cmd == `CMD_SPECIFY) || (cmd == `CMD_SENSE_INT) || (cmd == `CMD_SEEK) ||
                       (cmd == `CMD_RECAL) || (cmd == `CMD_READ) || (cmd == `CMD_WRITE) ||
                       (cmd == `CMD_SENSE_DRIVE);
// A pending seek interrupt turns anything but sense interrupt into undefined
wire        invalid = !is_known || (sense_pending_reg && cmd != `CMD_SENSE_INT);
wire        mapped = (PADDR_I[11:2] <= 10'h008) && (PADDR_I[1:0] == 2'h0);

always @(posedge CLOCK_I) begin
  if (!RST_N_I) begin
    PREADY_O  <= 1'b0;
    PSLVERR_O <= 1'b0;
    PRDATA_O  <= 32'h0;
  end else begin
    PREADY_O  <= PSEL_I & PENABLE_I & ~PREADY_O;
    PSLVERR_O <= PSEL_I & PENABLE_I & ~PREADY_O & ~mapped;
    PRDATA_O  <= 32'h0;
    if (rd_acc) begin
      if (PADDR_I == `OFS_SPECIFY)
        PRDATA_O <= {17'h0, head_settle_delay, step_interval_setting, head_unload_timer};
      else if (PADDR_I == `OFS_CONTROL)
        PRDATA_O <= {31'h0, programmed_transfer_select};
      else if (PADDR_I == `OFS_MAIN_STATUS)
        PRDATA_O <= {24'h0, request_for_master_bit, transfer_direction_bit, 4'h0,
                     state_reg != ST_IDLE, sense_pending_reg};
      else if (PADDR_I == `OFS_RESULT_ST0)
        PRDATA_O <= {24'h0, first_result_status};
      else if (PADDR_I == `OFS_RESULT_ST1)
        PRDATA_O <= {24'h0, result_status_1};
      else if (PADDR_I == `OFS_CYLINDER)
        PRDATA_O <= {24'h0, present_cylinder_number};
      else if (PADDR_I == `OFS_TIMERS)
        PRDATA_O <= {16'h0, unload_left_reg, ms_left_reg};
    end
  end
end

// ****************************************************************
// Command, seek and timer engine
// ****************************************************************
wire tick_done = (tick_reg == ms_cycles - 24'h1);
wire ev_fault  = DRIVE_EVENT_I[`EV_DRIVE_FAULT];

always @(posedge CLOCK_I) begin
  if (!RST_N_I) begin
    state_reg <= ST_IDLE;
    head_unload_timer <= 4'h1;
    step_interval_setting <= 4'hf;
    head_settle_delay <= 7'h1;
    programmed_transfer_select <= 1'b0;
    present_cylinder_number <= 8'h0;
    target_cyl_reg <= 8'h0;
    recal_reg <= 1'b0;
    step_count_reg <= 7'h0;
    termination_code <= `TC_NORMAL;
    seek_code_reg <= 3'h0;
    {seek_done_flag, equipment_fault_flag, drive_not_ready_flag} <= 3'h0;
    {end_cyl_flag, crc_error_flag, overrun_flag, no_data_flag} <= 4'h0;
    {write_protect_hit_flag, missing_mark_flag} <= 2'h0;
    sense_pending_reg <= 1'b0;
    transfer_direction_bit <= 1'b0;
    request_for_master_bit <= 1'b1;
    tick_reg <= 24'h0;
    ms_left_reg <= 8'h0;
    unload_left_reg <= 8'h0;
    unload_tick_reg <= 24'h0;
    // Track the pin level so release of reset shows no false ready change
    ready_last_reg <= ready_s;
    INTERRUPT_O <= 1'b0;
    STEP_O <= 1'b0;
    DIRECTION_O <= 1'b0;
    HEAD_LOAD_O <= 1'b0;
    RW_START_O <= 1'b0;
    PROGRAMMED_TRANSFER_O <= 1'b0;
  end else begin
    ready_last_reg <= ready_s;
    RW_START_O <= 1'b0;
    STEP_O <= 1'b0;
    PROGRAMMED_TRANSFER_O <= programmed_transfer_select;
    if (wr_acc && PADDR_I == `OFS_CONTROL) begin
      programmed_transfer_select <= PWDATA_I[0];
      PROGRAMMED_TRANSFER_O <= PWDATA_I[0];
    end
    // Reading result byte releases the result phase
    if (rd_acc && PADDR_I == `OFS_RESULT_ST0) begin
      transfer_direction_bit <= 1'b0;
      request_for_master_bit <= 1'b1;
    end
    // Ready change while idle raises a seek-class interrupt
    if (ready_s != ready_last_reg && state_reg == ST_IDLE) begin
      seek_code_reg <= `SEEK_READY_CODE;
      sense_pending_reg <= 1'b1;
      INTERRUPT_O <= 1'b1;
    end
    if (cmd_wr && state_reg == ST_IDLE) begin
      if (invalid) begin
        termination_code <= `TC_INVALID;
        {seek_done_flag, equipment_fault_flag, drive_not_ready_flag} <= 3'h0;
        transfer_direction_bit <= 1'b1;
        request_for_master_bit <= 1'b1;
        sense_pending_reg <= 1'b0;
      end else if (cmd == `CMD_SENSE_INT) begin
        INTERRUPT_O <= 1'b0;
        {seek_done_flag, termination_code} <= seek_code_reg;
        sense_pending_reg <= 1'b0;
        transfer_direction_bit <= 1'b1;
      end else if (cmd == `CMD_SPECIFY) begin
        head_unload_timer <= PWDATA_I[11:8];
        step_interval_setting <= PWDATA_I[15:12];
        head_settle_delay <= PWDATA_I[22:16];
      end else if (cmd == `CMD_SEEK || cmd == `CMD_RECAL) begin
        recal_reg <= (cmd == `CMD_RECAL);
        target_cyl_reg <= (cmd == `CMD_RECAL) ? 8'h0 : PWDATA_I[15:8];
        DIRECTION_O <= (cmd == `CMD_RECAL) || (PWDATA_I[15:8] < present_cylinder_number);
        step_count_reg <= 7'h0;
        equipment_fault_flag <= ev_fault;
        ms_left_reg <= 8'h0;
        tick_reg <= 24'h0;
        state_reg <= ST_SEEK;
      end else if (cmd == `CMD_READ || cmd == `CMD_WRITE) begin
        {end_cyl_flag, crc_error_flag, overrun_flag, no_data_flag} <= 4'h0;
        {write_protect_hit_flag, missing_mark_flag} <= 2'h0;
        equipment_fault_flag <= ev_fault;
        seek_done_flag <= 1'b0;
        if (!ready_s || (PWDATA_I[8] && !twoside_s)) begin
          drive_not_ready_flag <= 1'b1;
          termination_code <= `TC_ABNORMAL;
          transfer_direction_bit <= 1'b1;
          INTERRUPT_O <= 1'b1;
        end else begin
          drive_not_ready_flag <= 1'b0;
          termination_code <= `TC_NORMAL;
          HEAD_LOAD_O <= 1'b1;
          unload_left_reg <= 8'h0;
          ms_left_reg <= {head_settle_delay, 1'b0};
          tick_reg <= 24'h0;
          state_reg <= ST_LOAD;
        end
      end
    end else if (state_reg == ST_SEEK) begin
      tick_reg <= tick_done ? 24'h0 : tick_reg + 24'h1;
      if (tick_done && ms_left_reg != 8'h0)
        ms_left_reg <= ms_left_reg - 8'h1;
      if (tick_done && ms_left_reg <= 8'h1) begin
        if (recal_reg ? track0_s : (present_cylinder_number == target_cyl_reg)) begin
          seek_code_reg <= `SEEK_NORMAL_CODE;
          if (recal_reg) present_cylinder_number <= 8'h0;
          sense_pending_reg <= 1'b1;
          INTERRUPT_O <= 1'b1;
          state_reg <= ST_IDLE;
        end else if (!ready_s || (recal_reg && step_count_reg == `RECAL_MAX_STEPS)) begin
          equipment_fault_flag <= recal_reg;
          seek_code_reg <= `SEEK_ABNORM_CODE;
          sense_pending_reg <= 1'b1;
          INTERRUPT_O <= 1'b1;
          state_reg <= ST_IDLE;
        end else begin
          STEP_O <= 1'b1;
          step_count_reg <= step_count_reg + 7'h1;
          if (!recal_reg)
            present_cylinder_number <= DIRECTION_O ? present_cylinder_number - 8'h1
                                                   : present_cylinder_number + 8'h1;
          ms_left_reg <= step_ms(step_interval_setting);
        end
      end
    end else if (state_reg == ST_LOAD) begin
      tick_reg <= tick_done ? 24'h0 : tick_reg + 24'h1;
      if (tick_done)
        ms_left_reg <= ms_left_reg - 8'h1;
      if (tick_done && ms_left_reg == 8'h1) begin
        RW_START_O <= 1'b1;
        state_reg <= ST_XFER;
      end
    end else if (state_reg == ST_XFER) begin
      if (RW_DONE_I) begin
        transfer_direction_bit <= 1'b1;
        INTERRUPT_O <= 1'b1;
        unload_left_reg <= {head_unload_timer, 4'h0};
        unload_tick_reg <= 24'h0;
        state_reg <= ST_IDLE;
      end
    end
    // Head unload countdown runs in idle after a transfer
    if (state_reg == ST_IDLE && unload_left_reg != 8'h0 && !cmd_wr) begin
      unload_tick_reg <= (unload_tick_reg == ms_cycles - 24'h1) ? 24'h0 : unload_tick_reg + 24'h1;
      if (unload_tick_reg == ms_cycles - 24'h1) begin
        unload_left_reg <= unload_left_reg - 8'h1;
        if (unload_left_reg == 8'h1) HEAD_LOAD_O <= 1'b0;
      end
    end
    // Result flags latch last so an event beats a command clear in one cycle
    if (DRIVE_EVENT_I[`EV_END_CYL]) end_cyl_flag <= 1'b1;
    if (DRIVE_EVENT_I[`EV_CRC]) crc_error_flag <= 1'b1;
    if (DRIVE_EVENT_I[`EV_OVERRUN]) overrun_flag <= 1'b1;
    if (DRIVE_EVENT_I[`EV_NO_DATA]) no_data_flag <= 1'b1;
    if (DRIVE_EVENT_I[`EV_WPROT]) write_protect_hit_flag <= 1'b1;
    if (DRIVE_EVENT_I[`EV_MISS_MARK]) missing_mark_flag <= 1'b1;
    if (ev_fault) equipment_fault_flag <= 1'b1;
  end
end

endmodule // fdc_status_timer

// ===== dv/fdc_status_timer_monitor.sv
/* Assertions on the status and timer block ports.
   Assumes binding to fdc_status_timer, 125 MHz, 20-cycle ms in sim. */
`timescale 1ns/100ps
`include "fdc_status_regs.vh"
module fdc_status_timer_monitor (
  input wire logic        CLOCK_I,
  input wire logic        RST_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic        RW_DONE_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        INTERRUPT_O,
  input wire logic        STEP_O,
  input wire logic        HEAD_LOAD_O,
  input wire logic        RW_START_O,
  input wire logic        PROGRAMMED_TRANSFER_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  wire       take = PSEL_I && PENABLE_I && !PREADY_O;
  wire       wcmd = take && PWRITE_I && PADDR_I == `OFS_COMMAND;
  wire [4:0] op   = PWDATA_I[4:0];
  wire       bad  = !(op inside {`CMD_SPECIFY, `CMD_SENSE_INT, `CMD_SEEK, `CMD_RECAL,
                                 `CMD_READ, `CMD_WRITE, `CMD_SENSE_DRIVE});
  AST_APB_WAIT: assert property (take |=> PREADY_O) else $error("pready late");
  AST_READY_PULSE: assert property (PREADY_O |=> !PREADY_O) else $error("pready held");
  AST_ERR_QUAL: assert property (PSLVERR_O |-> PREADY_O) else $error("pslverr alone");
  AST_RDATA_IDLE: assert property (!PREADY_O |-> PRDATA_O == 32'h0) else $error("prdata idle");
  AST_SENSE_CLEAR: assert property (wcmd && op == `CMD_SENSE_INT |=> ##[0:2] !INTERRUPT_O)
    else $error("interrupt not cleared");
  AST_INVALID_QUIET: assert property (wcmd && bad && !INTERRUPT_O |=> !INTERRUPT_O [*4])
    else $error("interrupt on undefined command");
  AST_STEP_GAP: assert property (STEP_O |=> !STEP_O [*8]) else $error("steps too close");
  AST_SETTLE: assert property (RW_START_O |-> HEAD_LOAD_O && $past(HEAD_LOAD_O, 39))
    else $error("start before settle");
  AST_UNLOAD_HOLD: assert property (HEAD_LOAD_O && RW_DONE_I |=> HEAD_LOAD_O [*8])
    else $error("early unload");
  AST_MODE_BIT: assert property (take && PWRITE_I && PADDR_I == `OFS_CONTROL
    |=> PROGRAMMED_TRANSFER_O == $past(PWDATA_I[0])) else $error("mode bit");
endmodule // fdc_status_timer_monitor
bind fdc_status_timer fdc_status_timer_monitor mon (.CLOCK_I, .RST_N_I, .PSEL_I, .PENABLE_I,
  .PWRITE_I, .PADDR_I, .PWDATA_I, .RW_DONE_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .INTERRUPT_O,
  .STEP_O, .HEAD_LOAD_O, .RW_START_O, .PROGRAMMED_TRANSFER_O);

// ===== dv/fdc_drive_model.sv
/* Behavioural disk drive: head position, track zero, step spacing.
   Assumes one-cycle step pulses on the block clock. */
`timescale 1ns/100ps
module fdc_drive_model (
  input  wire logic clk_i,
  input  wire logic step_i,
  input  wire logic dir_i,
  input  wire logic stuck_i,
  output logic      track_zero_o,
  output int        pos_o,
  output int        gap_o,
  output int        steps_o
);
  int since = 0;
  initial pos_o = 0;
  initial gap_o = 0;
  initial steps_o = 0;
  // Stuck sensor models a head that never finds track zero
  assign track_zero_o = (pos_o == 0) && !stuck_i;
  always @(posedge clk_i) begin
    since <= since + 1;
    if (step_i) begin
      gap_o   <= since + 1;
      since   <= 0;
      steps_o <= steps_o + 1;
      pos_o   <= dir_i ? ((pos_o > 0) ? pos_o - 1 : 0) : pos_o + 1;
    end
  end
endmodule // fdc_drive_model

// ===== dv/fdc_status_and_timer_control_bench.sv
/* Self-checking bench for the status and timer block.
   Assumes the drive model and 20 clock cycles per ms. */
`timescale 1ns/100ps
`include "fdc_status_regs.vh"
`define CHK(a,b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module fdc_status_and_timer_control_bench;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, is4m = 0, rdy = 1, two = 0, done = 0;
  logic        stuck = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [7:0]  ev = 8'h00;
  logic        pready, pslverr, irq, step, dir, hl, rws, ptx, tz;
  int          n_mismatch = 0, cmp_count = 0, pos, gap, steps, n, s0;
  always #4 clk = ~clk;
  fdc_status_timer #(.MS_CYCLES_8M(20)) dut (.CLOCK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .CLOCK_IS_4M_I(is4m),
    .DRIVE_READY_I(rdy), .TRACK_ZERO_I(tz), .TWO_SIDED_I(two), .DRIVE_EVENT_I(ev),
    .RW_DONE_I(done), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .INTERRUPT_O(irq), .STEP_O(step), .DIRECTION_O(dir), .HEAD_LOAD_O(hl), .RW_START_O(rws),
    .PROGRAMMED_TRANSFER_O(ptx));
  fdc_drive_model drv (.clk_i(clk), .step_i(step), .dir_i(dir), .stuck_i(stuck),
    .track_zero_o(tz), .pos_o(pos), .gap_o(gap), .steps_o(steps));
  // ****************************************************************
  // Bus and wait helpers
  // ****************************************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk); psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk); pen <= 1;
    // Ends when pready rises; only the watchdog ends it if pready never does
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1, a, d); endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e); apb(0, a, 0); `CHK(q, e) endtask
  task automatic wfor(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin @(posedge clk); n++; end
    `CHK(s, v)
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_regs;
    rd(`OFS_MAIN_STATUS, 32'h80);
    rd(12'h100, 32'h0);
    `CHK(err, 1'b1)
    wr(`OFS_CONTROL, 32'h1); `CHK(ptx, 1'b1)
    wr(`OFS_CONTROL, 32'h0); `CHK(ptx, 1'b0)
  endtask
  task t_invalid;
    wr(`OFS_COMMAND, 32'h1f);
    repeat (4) @(posedge clk);
    `CHK(irq, 1'b0)
    rd(`OFS_MAIN_STATUS, 32'hc0);
    rd(`OFS_RESULT_ST0, 32'h80);
  endtask
  task t_seek;
    wr(`OFS_COMMAND, 32'h0001e103);
    wr(`OFS_COMMAND, 32'h0000030f);
    wfor(irq, 1, 2000);
    `CHK(pos, 3)
    `CHK(gap, 40)
    wr(`OFS_COMMAND, 32'h08); `CHK(irq, 1'b0)
    rd(`OFS_RESULT_ST0, 32'h20);
    rd(`OFS_CYLINDER, 32'h3);
  endtask
  task t_recal;
    stuck <= 1;
    s0 = steps;
    wr(`OFS_COMMAND, 32'h07);
    wfor(irq, 1, 4000);
    `CHK(steps - s0, 77)
    wr(`OFS_COMMAND, 32'h08);
    rd(`OFS_RESULT_ST0, 32'h70);
    stuck <= 0;
  endtask
  task t_rw(input logic m);
    is4m <= m;
    wr(`OFS_COMMAND, 32'h106);
    wfor(irq, 1, 200);
    rd(`OFS_RESULT_ST0, 32'h48);
    wr(`OFS_COMMAND, 32'h08); `CHK(irq, 1'b0)
    wr(`OFS_COMMAND, 32'h06);
    wfor(hl, 1, 50);
    wfor(rws, 1, 400);
    `CHK(n >= 40 * (m + 1) && n <= 40 * (m + 1) + 2, 1'b1)
    if (m) begin ev <= 8'h7f; @(posedge clk); ev <= 8'h00; end
    done <= 1; @(posedge clk); done <= 0;
    wfor(hl, 0, 1500);
    `CHK(n >= 320 * (m + 1) && n <= 320 * (m + 1) + 2, 1'b1)
    `CHK(irq, 1'b1)
    if (m) rd(`OFS_RESULT_ST1, 32'hb7);
    else rd(`OFS_RESULT_ST0, 32'h0);
    wr(`OFS_COMMAND, 32'h08); `CHK(irq, 1'b0)
  endtask
  task t_skip_sense;
    wr(`OFS_COMMAND, 32'h0000010f);
    wfor(irq, 1, 500);
    wr(`OFS_COMMAND, 32'h04);
    rd(`OFS_RESULT_ST0, 32'h80);
    wr(`OFS_COMMAND, 32'h08); `CHK(irq, 1'b0)
    rdy <= 0;
    wfor(irq, 1, 20);
    wr(`OFS_COMMAND, 32'h08); `CHK(irq, 1'b0)
    rd(`OFS_RESULT_ST0, 32'hc0);
  endtask
  task give_verdict;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog sized well above the longest path of all scenarios
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    t_regs;
    t_invalid;
    t_seek;
    t_recal;
    t_rw(0);
    t_rw(1);
    t_skip_sense;
    give_verdict;
  end
endmodule // fdc_status_and_timer_control_bench
